// ==== logic/rfs_pkg.sv ====
// Constants, register map and state encoding of the regulator fault supervisor.
// Assumes a 50 MHz core clock and comparator flags already on that clock.
// How it works
// - Power-good low until start done plus delay
// - Any fault except channel limit, or disable, drops power-good
// - Below half target flags undervoltage, drops power-good
// - Power-good returns at sixty percent of target
// - Overvoltage watch armed from supply good onward
// - Fixed trip until valid ID, then ID-based
// - Overvoltage drives all phases low within cycle
// - Release to high impedance, relow on recurrence
// - Overvoltage latch cleared only by enable/supply
// - Average current over reference starts shutdown
// - Overcurrent: high impedance for 4096 switching cycles
// - After wait, restart soft-start while enabled
// - Channel over limit: low rest of cycle
// - Channel limit never shuts converter down
// - Thermal outputs open-drain, valid once enabled
// - Fan request: release below 33%, low above 39%
// - Overtemp alert: release below 28%, low above 33%
// - Off code after plateau shuts down, latched
// - Fixed 85 us delay before power-good rises

package rfs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 20;
  localparam int unsigned PGOOD_DELAY_NS     = 85000;
  localparam int unsigned OC_WAIT_SW_CYCLES  = 4096;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_FAULT  = 4'h8;
  localparam int          CTRL_EN     = 0;
  localparam logic        CTRL_RESET  = 1'h1;
  localparam int          STAT_UV     = 6;
  localparam int          STAT_PGOOD  = 7;
  localparam int          STAT_FAN    = 8;
  localparam int          STAT_HOT    = 9;
  localparam int          STAT_IDOK   = 10;
  localparam int          FAULT_W     = 5;
  localparam int          FLT_OV      = 0;
  localparam int          FLT_OC      = 1;
  localparam int          FLT_UV      = 2;
  localparam int          FLT_IDOFF   = 3;
  localparam int          FLT_CHLIM   = 4;

  // ----------------------------------------
  // Pin synchroniser lanes
  // ----------------------------------------
  localparam int PIN_POR = 0;
  localparam int PIN_PWR = 1;
  localparam int PIN_VTT = 2;

  // ----------------------------------------
  // Supervisor states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_OFF    = 6'h01,
    ST_START  = 6'h02,
    ST_RUN    = 6'h04,
    ST_OCWAIT = 6'h08,
    ST_OVLATCH = 6'h10,
    ST_IDOFF  = 6'h20
  } rfs_state_t;

endpackage

// ==== logic/rfs_supervisor.sv ====
// Fault supervisor: power-good, undervoltage, overvoltage latch, hiccup overcurrent,
// per-channel current limit and thermal alerts.
// Assumes comparator flags and the soft-start handshake are on core_clk; enables and
// supply-good arrive from pins and are synchronised here.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps

module rfs_supervisor #(
  parameter int          NUM_PHASES         = 6,
  parameter int unsigned PGOOD_DELAY_CYCLES =
    rfs_pkg::PGOOD_DELAY_NS / rfs_pkg::CLK_PERIOD_NS,
  parameter int unsigned OC_WAIT_SW_CYCLES  = rfs_pkg::OC_WAIT_SW_CYCLES
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // Supply and enable pins
  input  wire logic                   por_ok_in,
  input  wire logic                   power_rail_enable_in,
  input  wire logic                   termination_rail_enable_in,
  // Switching timebase and soft-start handshake
  input  wire logic                   cycle_start_in,
  input  wire logic                   boot_plateau_done_in,
  input  wire logic                   id_valid_in,
  input  wire logic                   id_off_in,
  input  wire logic                   softstart_done_in,
  output logic                        softstart_run_out,
  // Comparator flags
  input  wire logic                   uv_entry_in,
  input  wire logic                   uv_recover_in,
  input  wire logic                   ov_fixed_trip_in,
  input  wire logic                   ov_id_trip_in,
  input  wire logic                   ov_release_in,
  input  wire logic                   oc_avg_trip_in,
  input  wire logic [NUM_PHASES-1:0]  ch_oc_trip_in,
  input  wire logic                   fan_set_in,
  input  wire logic                   fan_clear_in,
  input  wire logic                   hot_set_in,
  input  wire logic                   hot_clear_in,
  // Phase PWM to drivers
  input  wire logic [NUM_PHASES-1:0]  pwm_in,
  output logic [NUM_PHASES-1:0]       pwm_out,
  output logic [NUM_PHASES-1:0]       pwm_oe,
  // Open-drain system flags
  output logic                        power_good_out,
  output logic                        power_good_oe,
  output logic                        fan_request_out,
  output logic                        fan_request_oe,
  output logic                        overtemp_alert_out,
  output logic                        overtemp_alert_oe
);

  localparam int PG_W = $clog2(PGOOD_DELAY_CYCLES + 1);
  localparam int OC_W = $clog2(OC_WAIT_SW_CYCLES + 1);
  localparam logic [PG_W-1:0] PG_MAX = PG_W'(PGOOD_DELAY_CYCLES);
  localparam logic [OC_W-1:0] OC_MAX = OC_W'(OC_WAIT_SW_CYCLES);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_lvl_reg;
  wire  [2:0] pin_raw   = {termination_rail_enable_in, power_rail_enable_in, por_ok_in};
  wire  [2:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  wire  [2:0] pin_lvl_next = (pin_s3_reg & pin_agree) | (pin_lvl_reg & ~pin_agree);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg  <= 3'h0;
      pin_s2_reg  <= 3'h0;
      pin_s3_reg  <= 3'h0;
      pin_lvl_reg <= 3'h0;
    end else begin
      pin_s1_reg  <= pin_raw;
      pin_s2_reg  <= pin_s1_reg;
      pin_s3_reg  <= pin_s2_reg;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  // ----------------------------------------
  // State and flag registers
  // ----------------------------------------
  rfs_pkg::rfs_state_t         state_reg;
  rfs_pkg::rfs_state_t         state_next;
  logic                        ctrl_en_reg;
  logic                        id_ok_reg;
  logic                        uv_flag_reg;
  logic                        ov_low_reg;
  logic [PG_W-1:0]             pg_cnt_reg;
  logic [OC_W-1:0]             oc_cnt_reg;
  logic [NUM_PHASES-1:0]       ch_lim_reg;
  logic                        fan_on_reg;
  logic                        hot_on_reg;
  logic [rfs_pkg::FAULT_W-1:0] fault_reg;

  // ----------------------------------------
  // Decoded conditions
  // ----------------------------------------
  wire por_ok    = pin_lvl_reg[rfs_pkg::PIN_POR];
  wire enabled   = por_ok && pin_lvl_reg[rfs_pkg::PIN_PWR] && pin_lvl_reg[rfs_pkg::PIN_VTT]
                   && ctrl_en_reg;
  wire ov_trip   = id_ok_reg ? ov_id_trip_in : ov_fixed_trip_in;
  wire ov_hit    = por_ok && ov_trip;
  wire active    = (state_reg == rfs_pkg::ST_START) || (state_reg == rfs_pkg::ST_RUN);
  wire oc_hit    = active && oc_avg_trip_in;
  wire id_off    = (state_reg == rfs_pkg::ST_START) && boot_plateau_done_in && id_off_in;
  wire oc_done   = oc_cnt_reg == OC_MAX;
  wire pg_done   = pg_cnt_reg == PG_MAX;

  // ----------------------------------------
  // Supervisor state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rfs_pkg::ST_OFF: begin
        if (ov_hit) begin
          state_next = rfs_pkg::ST_OVLATCH;
        end else if (enabled) begin
          state_next = rfs_pkg::ST_START;
        end
      end
      rfs_pkg::ST_START: begin
        if (ov_hit) begin
          state_next = rfs_pkg::ST_OVLATCH;
        end else if (!enabled) begin
          state_next = rfs_pkg::ST_OFF;
        end else if (oc_hit) begin
          state_next = rfs_pkg::ST_OCWAIT;
        end else if (id_off) begin
          state_next = rfs_pkg::ST_IDOFF;
        end else if (softstart_done_in && id_ok_reg) begin
          state_next = rfs_pkg::ST_RUN;
        end
      end
      rfs_pkg::ST_RUN: begin
        if (ov_hit) begin
          state_next = rfs_pkg::ST_OVLATCH;
        end else if (!enabled) begin
          state_next = rfs_pkg::ST_OFF;
        end else if (oc_hit) begin
          state_next = rfs_pkg::ST_OCWAIT;
        end
      end
      rfs_pkg::ST_OCWAIT: begin
        if (ov_hit) begin
          state_next = rfs_pkg::ST_OVLATCH;
        end else if (!enabled) begin
          state_next = rfs_pkg::ST_OFF;
        end else if (oc_done) begin
          state_next = rfs_pkg::ST_START;
        end
      end
      rfs_pkg::ST_OVLATCH: begin
        // Only a dropped enable or supply clears the latch; ID changes do not.
        if (!enabled && !ov_hit) begin
          state_next = rfs_pkg::ST_OFF;
        end
      end
      rfs_pkg::ST_IDOFF: begin
        if (ov_hit) begin
          state_next = rfs_pkg::ST_OVLATCH;
        end else if (!enabled) begin
          state_next = rfs_pkg::ST_OFF;
        end
      end
      default: begin
        state_next = rfs_pkg::ST_OFF;
      end
    endcase
  end

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  wire in_start      = state_reg == rfs_pkg::ST_START;
  wire stay_run      = (state_reg == rfs_pkg::ST_RUN) && (state_next == rfs_pkg::ST_RUN);
  wire in_ov_next    = state_next == rfs_pkg::ST_OVLATCH;
  // While enabled the latch keeps the ID threshold; an overcurrent retry re-reads the code.
  wire id_ok_next    = (in_start && boot_plateau_done_in && id_valid_in && !id_off_in)
                       || (id_ok_reg && active)
                       || (id_ok_reg && enabled && (state_reg == rfs_pkg::ST_OVLATCH));
  wire uv_flag_next  = uv_entry_in || (uv_flag_reg && !uv_recover_in);
  wire ov_low_next   = in_ov_next && (ov_hit || (ov_low_reg && !ov_release_in));
  // The delay only starts once the ramp is final; leaving run restarts it.
  wire [PG_W-1:0] pg_cnt_next = !stay_run ? '0 :
                                pg_done   ? pg_cnt_reg : pg_cnt_reg + 1'b1;
  wire [OC_W-1:0] oc_cnt_next = (state_reg != rfs_pkg::ST_OCWAIT) ? '0 :
                                (cycle_start_in && !oc_done) ? oc_cnt_reg + 1'b1 : oc_cnt_reg;
  wire pgood_next    = stay_run && pg_done && !uv_flag_next;
  // A trip in the same cycle as the cycle boundary keeps the channel blocked.
  wire [NUM_PHASES-1:0] ch_lim_next = ch_oc_trip_in
                                      | (ch_lim_reg & {NUM_PHASES{!cycle_start_in}});
  wire [NUM_PHASES-1:0] ch_block    = ch_lim_reg | ch_oc_trip_in;
  wire run_next      = (state_next == rfs_pkg::ST_START) || (state_next == rfs_pkg::ST_RUN);
  wire [NUM_PHASES-1:0] pwm_out_next = run_next ? (pwm_in & ~ch_block) : '0;
  wire [NUM_PHASES-1:0] pwm_oe_next  = {NUM_PHASES{run_next || ov_low_next}};
  wire fan_next      = fan_set_in || (fan_on_reg && !fan_clear_in);
  wire hot_next      = hot_set_in || (hot_on_reg && !hot_clear_in);

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire wr_ctrl  = reg_wr && (reg_addr == rfs_pkg::ADDR_CTRL);
  wire wr_fault = reg_wr && (reg_addr == rfs_pkg::ADDR_FAULT);
  wire [rfs_pkg::FAULT_W-1:0] fault_evt;
  assign fault_evt[rfs_pkg::FLT_OV]     = in_ov_next && (state_reg != rfs_pkg::ST_OVLATCH);
  assign fault_evt[rfs_pkg::FLT_OC]     = oc_hit && !ov_hit && enabled;
  assign fault_evt[rfs_pkg::FLT_UV]     = uv_entry_in && !uv_flag_reg;
  assign fault_evt[rfs_pkg::FLT_IDOFF]  = id_off && !ov_hit && enabled;
  assign fault_evt[rfs_pkg::FLT_CHLIM]  = |ch_oc_trip_in;
  wire [rfs_pkg::FAULT_W-1:0] fault_clr = wr_fault ? reg_wdata[rfs_pkg::FAULT_W-1:0] : '0;
  // Set wins over a write-one-to-clear in the same cycle.
  wire [rfs_pkg::FAULT_W-1:0] fault_next = (fault_reg & ~fault_clr) | fault_evt;
  wire [31:0] status_word;
  assign status_word = {21'h0, id_ok_reg, hot_on_reg, fan_on_reg, !power_good_oe,
                        uv_flag_reg, state_reg};
  wire [31:0] rd_mux = (reg_addr == rfs_pkg::ADDR_CTRL)   ? {31'h0, ctrl_en_reg} :
                       (reg_addr == rfs_pkg::ADDR_STATUS) ? status_word :
                       (reg_addr == rfs_pkg::ADDR_FAULT)  ? {27'h0, fault_reg} : 32'h0;

  // ----------------------------------------
  // Sequential logic
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= rfs_pkg::ST_OFF;
      ctrl_en_reg <= rfs_pkg::CTRL_RESET;
      id_ok_reg   <= 1'b0;
      uv_flag_reg <= 1'b0;
      ov_low_reg  <= 1'b0;
      pg_cnt_reg  <= '0;
      oc_cnt_reg  <= '0;
      ch_lim_reg  <= '0;
      fan_on_reg  <= 1'b0;
      hot_on_reg  <= 1'b0;
      fault_reg   <= '0;
    end else begin
      state_reg   <= state_next;
      ctrl_en_reg <= wr_ctrl ? reg_wdata[rfs_pkg::CTRL_EN] : ctrl_en_reg;
      id_ok_reg   <= id_ok_next;
      uv_flag_reg <= uv_flag_next;
      ov_low_reg  <= ov_low_next;
      pg_cnt_reg  <= pg_cnt_next;
      oc_cnt_reg  <= oc_cnt_next;
      ch_lim_reg  <= ch_lim_next;
      fan_on_reg  <= fan_next;
      hot_on_reg  <= hot_next;
      fault_reg   <= fault_next;
    end
  end

  // Outputs, each straight from a flop.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata          <= 32'h0;
      softstart_run_out  <= 1'b0;
      pwm_out            <= '0;
      pwm_oe             <= '0;
      power_good_out     <= 1'b0;
      power_good_oe      <= 1'b1;
      fan_request_out    <= 1'b0;
      fan_request_oe     <= 1'b1;
      overtemp_alert_out <= 1'b0;
      overtemp_alert_oe  <= 1'b1;
    end else begin
      reg_rdata          <= reg_rd ? rd_mux : 32'h0;
      softstart_run_out  <= run_next;
      pwm_out            <= pwm_out_next;
      pwm_oe             <= pwm_oe_next;
      power_good_out     <= 1'b0;
      power_good_oe      <= !pgood_next;
      // Open-drain: released means oe low; the system reads them only once enabled.
      fan_request_out    <= 1'b0;
      fan_request_oe     <= !fan_next;
      overtemp_alert_out <= 1'b0;
      overtemp_alert_oe  <= !hot_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  pg_only_run_a:
    assert property (!power_good_oe |-> state_reg == rfs_pkg::ST_RUN)
    else $error("power-good released outside run");
  pg_delay_a:
    assert property ($fell(power_good_oe) |-> $past(pg_cnt_reg) == PG_MAX)
    else $error("power-good released before delay");
  pg_fault_a:
    assert property ((state_reg == rfs_pkg::ST_RUN && (ov_hit || oc_avg_trip_in || !enabled))
                     |=> power_good_oe)
    else $error("power-good held on fault or disable");
  uv_drop_a:
    assert property (uv_entry_in |=> power_good_oe && uv_flag_reg)
    else $error("undervoltage did not drop power-good");
  uv_recover_a:
    assert property ($fell(uv_flag_reg) |-> $past(uv_recover_in) && !$past(uv_entry_in))
    else $error("undervoltage cleared without recovery");
  ov_low_a:
    assert property (ov_hit |=> pwm_oe == '1 && pwm_out == '0)
    else $error("phases not driven low on overvoltage");
  ov_hiz_a:
    assert property ((in_ov_next && !ov_hit && ov_release_in) |=> pwm_oe == '0)
    else $error("phases not released after overvoltage fell");
  ov_latch_a:
    assert property ((state_reg == rfs_pkg::ST_OVLATCH && enabled) |=>
                     state_reg == rfs_pkg::ST_OVLATCH)
    else $error("overvoltage latch left while enabled");
  oc_hiz_a:
    assert property ((oc_hit && !ov_hit && enabled) |=>
                     state_reg == rfs_pkg::ST_OCWAIT && pwm_oe == '0)
    else $error("overcurrent did not float the phases");
  oc_retry_a:
    assert property ((state_reg == rfs_pkg::ST_OCWAIT && oc_done && enabled && !ov_hit) |=>
                     state_reg == rfs_pkg::ST_START)
    else $error("no retry after overcurrent wait");
  ch_limit_a:
    assert property ((ch_oc_trip_in[0] && !cycle_start_in) |=> !pwm_out[0] ##1 !pwm_out[0])
    else $error("channel not held low after limit");
  fan_a:
    assert property (fan_set_in |=> !fan_request_oe)
    else $error("fan request not released");
  hot_a:
    assert property ((hot_clear_in && !hot_set_in) |=> overtemp_alert_oe)
    else $error("overtemp alert not pulled low");

  pg_rise_c:  cover property ($fell(power_good_oe));
  oc_retry_c: cover property (state_reg == rfs_pkg::ST_OCWAIT ##1 state_reg == rfs_pkg::ST_START);
  ov_cycle_c: cover property (ov_low_reg ##1 !ov_low_reg ##[1:20] ov_low_reg);

endmodule

// ==== verification/rfs_driver_model.sv ====
// Model of the phase driver chips and of the board pull-ups on the supervisor's flags.
// Assumes every supervisor output drives its pin while its enable is high.
`timescale 1ns/1ps

module rfs_driver_model #(
  parameter int NUM_PHASES = 6
) (
  // Supervisor outputs
  input  wire logic [NUM_PHASES-1:0] pwm_out,
  input  wire logic [NUM_PHASES-1:0] pwm_oe,
  input  wire logic                  power_good_out,
  input  wire logic                  power_good_oe,
  input  wire logic                  fan_request_out,
  input  wire logic                  fan_request_oe,
  input  wire logic                  overtemp_alert_out,
  input  wire logic                  overtemp_alert_oe,
  // Switch state and flag lines as the board sees them
  output logic      [NUM_PHASES-1:0] high_on,
  output logic      [NUM_PHASES-1:0] low_on,
  output logic                       power_good_line,
  output logic      [1:0]            thermal_line
);
  // ----------------------------------------
  // Drivers and pull-ups
  // ----------------------------------------
  // A floating PWM input turns both switches off, so no stale pin level survives.
  assign high_on = pwm_oe & pwm_out;
  assign low_on  = pwm_oe & ~pwm_out;
  // Thermal lines mean something only once the supervisor is enabled.
  assign power_good_line = power_good_oe ? power_good_out : 1'b1;
  assign thermal_line[0] = fan_request_oe ? fan_request_out : 1'b1;
  assign thermal_line[1] = overtemp_alert_oe ? overtemp_alert_out : 1'b1;
endmodule

// ==== verification/test_regulator_fault_supervisor.sv ====
// Self-checking bench for the regulator fault supervisor.
// Assumes the driver model beside it and shortened delay and wait counts.
`timescale 1ns/1ps

module test_regulator_fault_supervisor;
  logic          core_clk, pg_line, ss_run, pg_out, pg_oe, fan_out, fan_oe, hot_out, hot_oe;
  logic          rst = 1'b1, por_ok = 1'b1, rail_en = 1'b1, term_en = 1'b1, uv_rec = 1'b1;
  logic          reg_wr = 1'b0, reg_rd = 1'b0, cyc_start = 1'b0, plateau = 1'b0;
  logic          id_valid = 1'b0, id_off = 1'b0, ss_done = 1'b0, uv_entry = 1'b0;
  logic          ov_fixed = 1'b0, ov_id = 1'b0, ov_rel = 1'b0, oc_avg = 1'b0;
  logic [3:0]    reg_addr = 4'h0;
  logic [31:0]   reg_wdata = 32'h0, reg_rdata, rv;
  logic [1:0]    th_set = 2'h0, th_clr = 2'h0, th_line;
  logic [5:0]    ch_trip = 6'h00, pwm_in = 6'h3F, pwm_out, pwm_oe, high_on, low_on;
  int            errors = 0, samples_checked = 0;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Delay and wait counts are shortened so that each scenario stays brief.
  rfs_supervisor #(.PGOOD_DELAY_CYCLES(20), .OC_WAIT_SW_CYCLES(4)) i_rfs_supervisor (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_ok_in(por_ok),
    .power_rail_enable_in(rail_en), .termination_rail_enable_in(term_en),
    .cycle_start_in(cyc_start), .boot_plateau_done_in(plateau), .id_valid_in(id_valid),
    .id_off_in(id_off), .softstart_done_in(ss_done), .softstart_run_out(ss_run),
    .uv_entry_in(uv_entry), .uv_recover_in(uv_rec), .ov_fixed_trip_in(ov_fixed),
    .ov_id_trip_in(ov_id), .ov_release_in(ov_rel), .oc_avg_trip_in(oc_avg),
    .ch_oc_trip_in(ch_trip), .fan_set_in(th_set[0]), .fan_clear_in(th_clr[0]),
    .hot_set_in(th_set[1]), .hot_clear_in(th_clr[1]), .pwm_in(pwm_in), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .power_good_out(pg_out), .power_good_oe(pg_oe),
    .fan_request_out(fan_out), .fan_request_oe(fan_oe), .overtemp_alert_out(hot_out),
    .overtemp_alert_oe(hot_oe));

  rfs_driver_model i_rfs_driver_model (
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .power_good_out(pg_out), .power_good_oe(pg_oe),
    .fan_request_out(fan_out), .fan_request_oe(fan_oe), .overtemp_alert_out(hot_out),
    .overtemp_alert_oe(hot_oe), .high_on(high_on), .low_on(low_on),
    .power_good_line(pg_line), .thermal_line(th_line));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  // Waits n edges, then settles at the falling edge so registered outputs have landed.
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk) reg_rd <= 1'b0;
    @(negedge core_clk) rv = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic st(input logic [5:0] s);
    rd(rfs_pkg::ADDR_STATUS);
    chk({26'h0, rv[5:0]}, {26'h0, s});
  endtask
  task automatic pulse;
    @(posedge core_clk) cyc_start <= 1'b1;
    @(posedge core_clk) cyc_start <= 1'b0;
  endtask
  task automatic test_done;
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    w(1);
    chb(pg_line, 1'b0);
    rd(4'hC);
    chk(rv, 32'h0);
    rd(rfs_pkg::ADDR_CTRL);
    chk(rv, 32'h1);
    w(6);
    st(6'h02);
    @(posedge core_clk) {plateau, id_valid, ss_done} <= 3'b111;
    w(8);
    st(6'h04);
    chb(pg_line, 1'b0);
    w(25);
    chb(pg_line, 1'b1);
    @(posedge core_clk) {uv_entry, uv_rec} <= 2'b10;
    w(2);
    chb(pg_line, 1'b0);
    rd(rfs_pkg::ADDR_STATUS);
    chk(rv, 32'h444);
    @(posedge core_clk) uv_entry <= 1'b0;
    w(3);
    chb(pg_line, 1'b0);
    @(posedge core_clk) uv_rec <= 1'b1;
    w(3);
    chb(pg_line, 1'b1);
    @(posedge core_clk) ch_trip <= 6'h01;
    @(posedge core_clk) {ch_trip, pwm_in} <= {6'h00, 6'h2D};
    w(2);
    chk({26'h0, high_on}, 32'h2C);
    chb(pg_line, 1'b1);
    pulse;
    w(2);
    chk({26'h0, high_on}, 32'h2D);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk) th_set[i] <= 1'b1;
      w(2);
      chb(th_line[i], 1'b1);
      @(posedge core_clk) th_set[i] <= 1'b0;
      w(2);
      chb(th_line[i], 1'b1);
      @(posedge core_clk) th_clr[i] <= 1'b1;
      w(2);
      chb(th_line[i], 1'b0);
      @(posedge core_clk) th_clr[i] <= 1'b0;
    end
    rd(rfs_pkg::ADDR_FAULT);
    chk(rv, 32'h14);
    wr(rfs_pkg::ADDR_FAULT, 32'h1F);
    rd(rfs_pkg::ADDR_FAULT);
    chk(rv, 32'h0);
    @(posedge core_clk) oc_avg <= 1'b1;
    @(posedge core_clk) oc_avg <= 1'b0;
    w(1);
    chk({20'h0, high_on, low_on}, 32'h0);
    chb(pg_line, 1'b0);
    st(6'h08);
    repeat (3) pulse;
    st(6'h08);
    pulse;
    w(2);
    chb(ss_run, 1'b1);
    w(26);
    st(6'h04);
    chb(pg_line, 1'b1);
    @(posedge core_clk) ov_id <= 1'b1;
    w(1);
    chk({26'h0, low_on}, 32'h3F);
    chb(pg_line, 1'b0);
    @(posedge core_clk) {ov_id, ov_rel} <= 2'b01;
    w(2);
    chk({20'h0, high_on, low_on}, 32'h0);
    @(posedge core_clk) {ov_id, ov_rel} <= 2'b10;
    w(1);
    chk({26'h0, low_on}, 32'h3F);
    @(posedge core_clk) {ov_id, id_valid} <= 2'b00;
    w(3);
    st(6'h10);
    chk({26'h0, high_on}, 32'h0);
    @(posedge core_clk) rail_en <= 1'b0;
    w(8);
    st(6'h01);
    @(posedge core_clk) {ov_id, ov_rel} <= 2'b10;
    w(2);
    chk({26'h0, low_on}, 32'h0);
    @(posedge core_clk) {ov_id, ov_fixed, ov_rel} <= 3'b010;
    w(1);
    chk({26'h0, low_on}, 32'h3F);
    @(posedge core_clk) {ov_fixed, ov_rel} <= 2'b01;
    w(3);
    st(6'h01);
    @(posedge core_clk) {id_off, rail_en} <= 2'b11;
    w(8);
    st(6'h20);
    chb(pg_line, 1'b0);
    @(posedge core_clk) {id_off, id_valid} <= 2'b01;
    w(4);
    st(6'h20);
    @(posedge core_clk) term_en <= 1'b0;
    w(6);
    @(posedge core_clk) term_en <= 1'b1;
    w(8);
    chb(ss_run, 1'b1);
    wr(rfs_pkg::ADDR_CTRL, 32'h0);
    w(2);
    chb(ss_run, 1'b0);
    st(6'h01);
    test_done;
  end

  // The scenarios need about 220 cycles; the watchdog allows more than ten times that.
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    test_done;
  end
endmodule
